// ===== pwmci_pkg.sv
/*
 * Constants for the PWM control-input conditioning block: APB register map,
 * field positions, reset values and the encodings of every select field.
 * Assumes a 32-bit APB master and a single 200 MHz generator clock.
 */
//
// Notes on behaviour
// [RL1] Four independent copies, each with two registers
// [RL2] Termination immediate or deferred to end of cycle
// [RL3] Stop-event select chooses the termination source
// [RL4] Code 000 terminates only on software strobe
// [RL5] Software stop bit pulses once, reads zero
// [RL6] Acceptance qualifier optionally inverted
// [RL7] Acceptance qualifier source select decoding
// [RL8] Qualifier code 000 forces one, 111 zero
// [RL9] Input optionally sampled at end of cycle
// [RL10] Input polarity optionally inverted
// [RL11] Five-bit input source select, reserved read zero
// [RL12] Code 00001 takes the generator output mux
// [RL13] Codes 00010/00011 take combined triggers A/B
// [RL14] Bypass takes another generator's input logic
// [RL15] Bypass select maps codes to generators 1-8
// [RL16] Absent generator selects constant zero
// [RL17] Acceptance criteria: level, edges, latched variants
// [RL18] Software drive bit presents its stored value
// [RL19] Drive target: acceptance, accept or stop qualifier
// [RL20] Latch dominance chooses reset-wins or set-wins
// [RL21] Stop qualifier: invert, force one/zero, sources
// [RL22] Qualifiers gate acceptance and termination
// [RL23] All fields reset to zero
`default_nettype none

package pwmci_pkg;

   // Register map: function f low word at 8*f, high word at 8*f+4
   localparam int PWMCI_NUM_FUNC = 4;
   localparam int PWMCI_ADDR_W = 12;
   localparam logic [PWMCI_ADDR_W-1:0] PWMCI_MAP_LIMIT = 12'h020;
   localparam logic [15:0] PWMCI_LOW_RESET = 16'h0000;
   localparam logic [15:0] PWMCI_HIGH_RESET = 16'h0000;
   // Writable bits; software stop bit is write-only, high bit 11 unimplemented
   localparam logic [15:0] PWMCI_LOW_RDMASK = 16'hFF7F;
   localparam logic [15:0] PWMCI_HIGH_WRMASK = 16'hF7FF;

   // Low register fields
   localparam int PWMCI_TSYNC_BIT = 15;
   localparam int PWMCI_TERM_POS = 12;
   localparam int PWMCI_AQINV_BIT = 11;
   localparam int PWMCI_AQSRC_POS = 8;
   localparam int PWMCI_SWSTOP_BIT = 7;
   localparam int PWMCI_INPUT_CYCLE_SYNC_BIT = 6;
   localparam int PWMCI_PINV_BIT = 5;
   localparam int PWMCI_PSS_POS = 0;
   // High register fields
   localparam int PWMCI_BYPASS_ENABLE_BIT = 15;
   localparam int PWMCI_BYPASS_GENERATOR_SELECT_POS = 12;
   localparam int PWMCI_ACP_POS = 8;
   localparam int PWMCI_SWBIT_BIT = 7;
   localparam int PWMCI_SWTGT_POS = 5;
   localparam int PWMCI_LATCH_DOMINANCE_MODE_BIT = 4;
   localparam int PWMCI_TQINV_BIT = 3;
   localparam int PWMCI_TQSRC_POS = 0;

   // Input source codes
   localparam logic [4:0] PWMCI_PSS_ZERO = 5'h00;
   localparam logic [4:0] PWMCI_PSS_GENMUX = 5'h01;
   localparam logic [4:0] PWMCI_PSS_COMBO_A = 5'h02;
   localparam logic [4:0] PWMCI_PSS_COMBO_B = 5'h03;
   localparam logic [31:0] PWMCI_EXT_USED = 32'hBFFF_FF00;

   // Qualifier source codes
   typedef enum logic [2:0] {
      PWMCI_Q_ONE = 3'b000, PWMCI_Q_DUTY = 3'b001, PWMCI_Q_BLANK = 3'b010,
      PWMCI_Q_TRIG = 3'b011, PWMCI_Q_GENMUX = 3'b100, PWMCI_Q_SRC8 = 3'b101,
      PWMCI_Q_SRC9 = 3'b110, PWMCI_Q_ZERO = 3'b111
   } pwmci_qual_t;

   // Termination event codes
   typedef enum logic [2:0] {
      PWMCI_T_SW = 3'b000, PWMCI_T_AUTO = 3'b001, PWMCI_T_TRIGA = 3'b010,
      PWMCI_T_TRIGB = 3'b011, PWMCI_T_TRIGC = 3'b100, PWMCI_T_GENMUX = 3'b101,
      PWMCI_T_SRC8 = 3'b110, PWMCI_T_SRC9 = 3'b111
   } pwmci_term_t;

   // Acceptance criteria
   typedef enum logic [2:0] {
      PWMCI_ACP_LEVEL = 3'b000, PWMCI_ACP_RISE = 3'b001, PWMCI_ACP_ANY = 3'b010,
      PWMCI_ACP_LATCH = 3'b011, PWMCI_ACP_LRISE = 3'b100, PWMCI_ACP_LANY = 3'b101,
      PWMCI_ACP_RSV6 = 3'b110, PWMCI_ACP_RSV7 = 3'b111
   } pwmci_acp_t;

   // Software drive targets
   localparam logic [1:0] PWMCI_SW_ACCEPT = 2'b00;
   localparam logic [1:0] PWMCI_SW_AQUAL = 2'b01;
   localparam logic [1:0] PWMCI_SW_TQUAL = 2'b10;

endpackage : pwmci_pkg

`default_nettype wire

// ===== pwmci_input_logic.sv
/*
 * Control-input conditioning for one PWM generator: four copies (fault,
 * current limit, feed-forward, sync) behind an APB slave.
 * Assumes trigger, end-of-cycle and generator signals come from logic on clk;
 * external source inputs and the two spare sources are asynchronous.
 */
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module pwmci_input_logic
#(
   parameter int NUM_GEN = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pwmci_pkg::PWMCI_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Generator timing, same clock
   input wire logic end_of_cycle,
   input wire logic duty_active,
   input wire logic blanking_active,
   input wire logic generator_triggered,
   input wire logic trigger_compare_a,
   input wire logic trigger_compare_b,
   input wire logic trigger_compare_c,
   input wire logic combo_trigger_a,
   input wire logic combo_trigger_b,
   // Generator output mux, same clock
   input wire logic [7:0] generator_outputs,
   input wire logic [2:0] generator_output_mux_select,
   // Asynchronous sources, indexed by input source code
   input wire logic [31:0] external_sources,
   input wire logic spare_source_8,
   input wire logic spare_source_9,
   // Bypass: local active of generator g, function f at bit 8*f+g
   input wire logic [31:0] peer_active,
   // Results per function
   output logic [pwmci_pkg::PWMCI_NUM_FUNC-1:0] local_active,
   output logic [pwmci_pkg::PWMCI_NUM_FUNC-1:0] function_active
);
   import pwmci_pkg::*;

   logic [15:0] low_reg [PWMCI_NUM_FUNC];
   logic [15:0] high_reg [PWMCI_NUM_FUNC];
   logic [PWMCI_NUM_FUNC-1:0] sw_stop_reg;
   logic [31:0] prdata_reg;
   logic [31:0] ext_meta_reg;
   logic [31:0] ext_sync_reg;
   logic [1:0] spare_meta_reg;
   logic [1:0] spare_sync_reg;

   // APB decode; read data is captured in the setup cycle, so pready can
   // be high on the first access cycle without a combinational read path
   wire setup_phase = psel & ~penable;
   wire access_phase = psel & penable;
   wire addr_ok = (paddr < PWMCI_MAP_LIMIT) && (paddr[1:0] == 2'b00);
   wire [1:0] sel_func = paddr[4:3];
   wire sel_high = paddr[2];
   wire wr_en = access_phase & pwrite & addr_ok;
   wire [15:0] wr_bytes = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   wire [15:0] rd_low = low_reg[sel_func] & PWMCI_LOW_RDMASK; // see [RL5]
   wire [15:0] rd_word = sel_high ? high_reg[sel_func] : rd_low;

   assign pready = access_phase;
   assign pslverr = access_phase & ~addr_ok;
   assign prdata = prdata_reg;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         prdata_reg <= 32'h0000_0000;
      else if (setup_phase)
         prdata_reg <= addr_ok ? {16'h0000, rd_word} : 32'h0000_0000;
   end

   // Configuration storage, one register pair per function
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < PWMCI_NUM_FUNC; i++)
         begin
            low_reg[i] <= PWMCI_LOW_RESET; // see [RL23]
            high_reg[i] <= PWMCI_HIGH_RESET; // see [RL23]
         end
         sw_stop_reg <= '0;
      end
      else
      begin
         for (int i = 0; i < PWMCI_NUM_FUNC; i++)
         begin
            if (wr_en && sel_func == i[1:0] && !sel_high)
               low_reg[i] <= (low_reg[i] & ~(wr_bytes & PWMCI_LOW_RDMASK))
                  | (pwdata[15:0] & wr_bytes & PWMCI_LOW_RDMASK); // see [RL1]
            if (wr_en && sel_func == i[1:0] && sel_high)
               high_reg[i] <= (high_reg[i] & ~(wr_bytes & PWMCI_HIGH_WRMASK))
                  | (pwdata[15:0] & wr_bytes & PWMCI_HIGH_WRMASK); // see [RL1]
            // One-cycle event, nothing stored in the register
            sw_stop_reg[i] <= wr_en && sel_func == i[1:0] && !sel_high
               && pstrb[0] && pwdata[PWMCI_SWSTOP_BIT]; // see [RL5]
         end
      end
   end

   // Two-flop synchronisers for pins, comparators and remapped inputs
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ext_meta_reg <= 32'h0000_0000;
         ext_sync_reg <= 32'h0000_0000;
         spare_meta_reg <= 2'b00;
         spare_sync_reg <= 2'b00;
      end
      else
      begin
         ext_meta_reg <= external_sources & PWMCI_EXT_USED;
         ext_sync_reg <= ext_meta_reg;
         spare_meta_reg <= {spare_source_9, spare_source_8};
         spare_sync_reg <= spare_meta_reg;
      end
   end

   wire src8 = spare_sync_reg[0];
   wire src9 = spare_sync_reg[1];

   // Generator output mux, zero for a generator the device lacks
   wire genmux_present = {29'd0, generator_output_mux_select} < NUM_GEN;
   wire genmux_sig = genmux_present & generator_outputs[generator_output_mux_select]; // see [RL16]

   // Source vector indexed by the five-bit select; reserved codes stay zero
   wire [31:0] source_vec = {ext_sync_reg[31:4], combo_trigger_b, combo_trigger_a,
      genmux_sig, 1'b0}; // see [RL11] see [RL12] see [RL13]

   // Every source is an argument: a call in a continuous assignment only
   // re-evaluates when one of its arguments changes
   function automatic logic qual_pick(input logic [2:0] code, input logic duty,
      input logic blank, input logic trig, input logic gm, input logic s8, input logic s9);
      logic q;
      q = 1'b0;
      case (pwmci_qual_t'(code))
         PWMCI_Q_ONE: q = 1'b1; // see [RL8]
         PWMCI_Q_DUTY: q = duty; // see [RL7]
         PWMCI_Q_BLANK: q = blank;
         PWMCI_Q_TRIG: q = trig;
         PWMCI_Q_GENMUX: q = gm;
         PWMCI_Q_SRC8: q = s8;
         PWMCI_Q_SRC9: q = s9;
         PWMCI_Q_ZERO: q = 1'b0; // see [RL8]
         default: q = 1'b0;
      endcase
      return q;
   endfunction : qual_pick

   genvar f;
   generate
      for (f = 0; f < PWMCI_NUM_FUNC; f++)
      begin : g_func
         logic sampled_reg;
         logic in_prev_reg;
         logic gated_prev_reg;
         logic latch_reg;
         logic pend_reg;
         logic out_reg;
         logic latch_next;
         logic set_cond;
         logic out_next;

         wire [15:0] lo = low_reg[f];
         wire [15:0] hi = high_reg[f];
         wire [4:0] input_source_select = lo[PWMCI_PSS_POS +: 5];
         wire [2:0] term_sel = lo[PWMCI_TERM_POS +: 3];
         wire [2:0] aq_sel = lo[PWMCI_AQSRC_POS +: 3];
         wire [2:0] tq_sel = hi[PWMCI_TQSRC_POS +: 3];
         wire [2:0] acceptance_criteria = hi[PWMCI_ACP_POS +: 3];
         wire [1:0] sw_tgt = hi[PWMCI_SWTGT_POS +: 2];
         wire sw_bit = hi[PWMCI_SWBIT_BIT]; // see [RL18]

         // Source, optional end-of-cycle sampling, then polarity
         wire raw_src = source_vec[input_source_select]; // see [RL11]
         wire synced_src = lo[PWMCI_INPUT_CYCLE_SYNC_BIT] ? sampled_reg : raw_src; // see [RL9]
         wire pol_src = synced_src ^ lo[PWMCI_PINV_BIT]; // see [RL10]
         wire in_sig = pol_src | (sw_tgt == PWMCI_SW_ACCEPT && sw_bit); // see [RL19]

         // Qualifiers; a forced-zero code passes only through the invert bit or the drive bit
         wire aq_raw = qual_pick(aq_sel, duty_active, blanking_active, generator_triggered,
            genmux_sig, src8, src9); // see [RL7]
         wire aq_sw = (sw_tgt == PWMCI_SW_AQUAL) && sw_bit; // see [RL19]
         wire aq = (aq_raw ^ lo[PWMCI_AQINV_BIT]) | aq_sw; // see [RL6]
         wire tq_raw = qual_pick(tq_sel, duty_active, blanking_active, generator_triggered,
            genmux_sig, src8, src9); // see [RL21]
         wire tq_sw = (sw_tgt == PWMCI_SW_TQUAL) && sw_bit; // see [RL19]
         wire tq = (tq_raw ^ hi[PWMCI_TQINV_BIT]) | tq_sw; // see [RL21]

         // Accepted input and its edges
         wire gated = in_sig & aq; // see [RL22]
         wire rise = gated & ~gated_prev_reg;
         wire any_edge = gated ^ gated_prev_reg;
         wire fall_in = in_prev_reg & ~in_sig;

         // Termination event
         logic term_evt;
         always_comb
         begin
            term_evt = 1'b0;
            case (pwmci_term_t'(term_sel))
               PWMCI_T_SW: term_evt = sw_stop_reg[f]; // see [RL4]
               PWMCI_T_AUTO: term_evt = fall_in; // see [RL3]
               PWMCI_T_TRIGA: term_evt = trigger_compare_a;
               PWMCI_T_TRIGB: term_evt = trigger_compare_b;
               PWMCI_T_TRIGC: term_evt = trigger_compare_c;
               PWMCI_T_GENMUX: term_evt = genmux_sig;
               PWMCI_T_SRC8: term_evt = src8;
               PWMCI_T_SRC9: term_evt = src9;
               default: term_evt = 1'b0;
            endcase
         end

         wire term_q = term_evt & tq; // see [RL22]
         // Deferred termination waits for the end of the current cycle
         wire reset_cond = lo[PWMCI_TSYNC_BIT] ? term_q
            : ((pend_reg | term_q) & end_of_cycle); // see [RL2]

         // Latch with selectable dominance
         always_comb
         begin
            set_cond = 1'b0;
            out_next = 1'b0;
            case (pwmci_acp_t'(acceptance_criteria))
               PWMCI_ACP_LATCH: set_cond = gated; // see [RL17]
               PWMCI_ACP_LRISE: set_cond = rise;
               PWMCI_ACP_LANY: set_cond = any_edge;
               default: set_cond = 1'b0;
            endcase
            if (set_cond && reset_cond)
               latch_next = ~hi[PWMCI_LATCH_DOMINANCE_MODE_BIT]; // see [RL20]
            else if (set_cond)
               latch_next = 1'b1;
            else if (reset_cond)
               latch_next = 1'b0;
            else
               latch_next = latch_reg;
            case (pwmci_acp_t'(acceptance_criteria))
               PWMCI_ACP_LEVEL: out_next = gated; // see [RL17]
               PWMCI_ACP_RISE: out_next = rise;
               PWMCI_ACP_ANY: out_next = any_edge;
               PWMCI_ACP_LATCH, PWMCI_ACP_LRISE, PWMCI_ACP_LANY: out_next = latch_next;
               default: out_next = 1'b0;
            endcase
         end

         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               sampled_reg <= 1'b0;
               in_prev_reg <= 1'b0;
               gated_prev_reg <= 1'b0;
               latch_reg <= 1'b0;
               pend_reg <= 1'b0;
               out_reg <= 1'b0;
            end
            else
            begin
               if (end_of_cycle)
                  sampled_reg <= raw_src; // see [RL9]
               in_prev_reg <= in_sig;
               gated_prev_reg <= gated;
               latch_reg <= latch_next;
               // A new termination on the end-of-cycle edge is consumed by it
               pend_reg <= lo[PWMCI_TSYNC_BIT] ? 1'b0
                  : ((pend_reg | term_q) & ~end_of_cycle); // see [RL2]
               out_reg <= out_next;
            end
         end

         // Bypass to the same function of another generator
         wire [7:0] peer = peer_active[f*8 +: 8];
         wire [2:0] bypass_generator_select = hi[PWMCI_BYPASS_GENERATOR_SELECT_POS +: 3];
         wire peer_ok = {29'd0, bypass_generator_select} < NUM_GEN; // see [RL16]
         wire peer_sig = peer_ok & peer[bypass_generator_select]; // see [RL15]

         assign local_active[f] = out_reg;
         assign function_active[f] = hi[PWMCI_BYPASS_ENABLE_BIT] ? peer_sig : out_reg; // see [RL14]
      end
   endgenerate

endmodule : pwmci_input_logic

`default_nettype wire

// ===== pwmci_checker.sv
/* Checker for the input-conditioning block: APB timing, read-back, routing.
   Assumes NUM_GEN of 8, so every bypass code names a present generator. */
`timescale 1ns/100ps
`default_nettype none
module pwmci_checker
(
   // Clock, reset and APB
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pwmci_pkg::PWMCI_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Results
   input wire logic [31:0] peer_active,
   input wire logic [pwmci_pkg::PWMCI_NUM_FUNC-1:0] local_active,
   input wire logic [pwmci_pkg::PWMCI_NUM_FUNC-1:0] function_active
);
   import pwmci_pkg::*;
   logic [15:0] shadow_reg [8];
   wire logic bad_addr = (paddr >= PWMCI_MAP_LIMIT) || (paddr[1:0] != 2'b00);
   wire logic [15:0] rd_mask = paddr[2] ? PWMCI_HIGH_WRMASK : PWMCI_LOW_RDMASK;
   // Shadow of software writes, so reads and bypass can be predicted
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         shadow_reg <= '{default: 16'h0000};
      else if (psel && penable && pwrite && !bad_addr)
         for (int b = 0; b < 2; b++)
            if (pstrb[b])
               shadow_reg[paddr[4:2]][8*b +: 8] <= pwdata[8*b +: 8];
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence read_s;
      psel && penable && !pwrite;
   endsequence
   zero_wait_a: assert property (setup_s ##1 penable |-> pready)
      else $error("no ready in first access cycle");
   idle_quiet_a: assert property (!penable |-> !pready && !pslverr)
      else $error("ready or error outside access");
   refuse_map_a: assert property (psel && penable |-> pslverr == bad_addr)
      else $error("error flag does not match address");
   read_back_a:
      assert property (read_s ##0 !bad_addr |-> prdata == {16'h0000, shadow_reg[paddr[4:2]] & rd_mask})
      else $error("read data differs from written value");
   refused_read_a: assert property (read_s ##0 bad_addr |-> prdata == 32'h0000_0000)
      else $error("refused read not zero");
   reset_clear_a:
      assert property ($rose(rstn) |-> (local_active | function_active) == 4'h0)
      else $error("results not clear after reset");
   for (genvar f = 0; f < PWMCI_NUM_FUNC; f++)
   begin : g_route
      wire logic byp = shadow_reg[2*f+1][15];
      wire logic [2:0] gsel = shadow_reg[2*f+1][14:12];
      bypass_route_a:
         assert property (byp |-> function_active[f] == peer_active[8*f+gsel])
         else $error("bypass result not from chosen generator");
      local_route_a: assert property (!byp |-> function_active[f] == local_active[f])
         else $error("local result not passed through");
   end
endmodule : pwmci_checker
bind pwmci_input_logic pwmci_checker u_checker (.clk(clk), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .peer_active(peer_active),
   .local_active(local_active), .function_active(function_active));
`default_nettype wire

// ===== pwmci_far_model.sv
/* Far-side model: generator end of cycle and the other generators' results.
   Assumes the bench gates the end of cycle while it checks deferral. */
`timescale 1ns/100ps
`default_nettype none
module pwmci_far_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Bench control
   input wire logic eoc_enable,
   // Far-side signals
   output logic end_of_cycle,
   output logic [31:0] peer_active
);
   logic [3:0] phase_reg;
   // Pseudo-random peer pattern, so a wrong or stale route soon shows
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_reg <= 4'h0;
         peer_active <= 32'h1357_9BDF;
      end
      else
      begin
         phase_reg <= phase_reg + 4'h1;
         peer_active <= {peer_active[30:0], peer_active[31] ^ peer_active[21]
            ^ peer_active[1] ^ peer_active[0]};
      end
   end
   // One-cycle pulse every 16 cycles
   assign end_of_cycle = eoc_enable && (phase_reg == 4'hF);
endmodule : pwmci_far_model
`default_nettype wire

// ===== testbench.sv
/* Bench: APB master, a table of source cases, then qualifier, latch,
   stop, bypass, register and reset tests. Assumes the far-side model. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import pwmci_pkg::*;
   logic clk, rstn, psel, penable, pwrite, c_a, c_b, eoc_en, eoc, pready, pslverr, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, ext, peer, rd;
   logic [3:0] pstrb, la, fa;
   logic [7:0] gout;
   logic [5:0] qv;
   logic [2:0] tv;
   int errors, total_checks;
   // Rows: source code, invert, source level, expected result
   logic [7:0] rows [8] = '{8'h02, 8'h05, 8'h0B, 8'h13, 8'h1E, 8'h43, 8'hFD, 8'hE8};
   pwmci_input_logic DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .end_of_cycle(eoc), .duty_active(qv[0]),
      .blanking_active(qv[1]), .generator_triggered(qv[2]), .trigger_compare_a(tv[0]),
      .trigger_compare_b(tv[1]), .trigger_compare_c(tv[2]), .combo_trigger_a(c_a),
      .combo_trigger_b(c_b), .generator_outputs(gout), .generator_output_mux_select(3'h2),
      .external_sources(ext), .spare_source_8(qv[4]), .spare_source_9(qv[5]),
      .peer_active(peer), .local_active(la), .function_active(fa));
   pwmci_far_model far (.clk(clk), .rstn(rstn), .eoc_enable(eoc_en),
      .end_of_cycle(eoc), .peer_active(peer));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
      input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Fixed waits follow the three-edge source path
   task automatic lvl(input logic exp, input int n, input string m);
      repeat (n) @(posedge clk);
      chk(la[0], exp, m);
   endtask : lvl
   initial
   begin
      #20000;
      errors++;
      print_verdict();
   end
   initial
   begin
      {psel, penable, pwrite, c_a, c_b, rstn, paddr, pwdata, pstrb} = '0;
      {ext, gout, qv, tv, errors, total_checks} = '0;
      eoc_en = 1'b1;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i])
      begin
         apb(1'b1, 12'h000, {10'h000, rows[i][2], rows[i][7:3]}, 4'h3);
         ext <= {32{~rows[i][1]}} ^ (32'h0000_0001 << rows[i][7:3]);
         c_a <= rows[i][1] ^ (rows[i][7:3] != 5'h02);
         c_b <= rows[i][1] ^ (rows[i][7:3] != 5'h03);
         gout <= {8{rows[i][1]}} ^ 8'hFB;
         lvl(rows[i][0], 5, "row");
      end
      ext <= 32'h0000_0100;
      for (int q = 0; q < 8; q++)
      begin
         apb(1'b1, 12'h000, {5'h00, q[2:0], 8'h08}, 4'h3);
         qv <= 6'h00;
         gout <= 8'h00;
         lvl(q == 0, 6, "qual off");
         qv <= 6'h3F;
         gout <= 8'hFF;
         lvl(q != 7, 6, "qual on");
      end
      apb(1'b1, 12'h000, 16'h0F08, 4'h3);
      lvl(1'b1, 4, "qual inv zero");
      apb(1'b1, 12'h000, 16'h0908, 4'h3);
      lvl(1'b0, 4, "qual inv duty");
      apb(1'b1, 12'h004, 16'h00A0, 4'h3);
      lvl(1'b1, 4, "drive qual");
      apb(1'b1, 12'h000, 16'h0000, 4'h3);
      apb(1'b1, 12'h004, 16'h0080, 4'h3);
      lvl(1'b1, 4, "drive accept");
      apb(1'b1, 12'h004, 16'h0300, 4'h3);
      apb(1'b1, 12'h000, 16'h8008, 4'h3);
      lvl(1'b1, 5, "latch set");
      ext <= 32'h0000_0000;
      lvl(1'b1, 5, "latch hold");
      apb(1'b1, 12'h000, 16'h8088, 4'h3);
      lvl(1'b0, 3, "sw stop");
      eoc_en <= 1'b0;
      ext <= 32'h0000_0100;
      apb(1'b1, 12'h000, 16'h0008, 4'h3);
      lvl(1'b1, 5, "latch again");
      ext <= 32'h0000_0000;
      apb(1'b1, 12'h000, 16'h0088, 4'h3);
      lvl(1'b1, 6, "stop deferred");
      eoc_en <= 1'b1;
      lvl(1'b0, 20, "stop at cycle end");
      {gout, qv} <= 14'h0000;
      for (int t = 1; t < 8; t++)
      begin
         ext <= 32'h0000_0100;
         apb(1'b1, 12'h000, {1'b1, t[2:0], 12'h008}, 4'h3);
         lvl(1'b1, 5, "stop set");
         ext <= 32'h0000_0000;
         lvl(t > 1, 6, "release");
         tv <= (t > 1 && t < 5) ? 3'h1 << (t - 2) : 3'h0;
         gout <= {5'h00, t == 5, 2'b00};
         qv <= {t == 7, t == 6, 4'h0};
         @(posedge clk);
         {tv, gout, qv} <= 17'h0_0000;
         lvl(1'b0, 3, "trigger stop");
      end
      // Set and stop in the same cycle: set-dominant, then reset-dominant
      ext <= 32'h0000_0100;
      apb(1'b1, 12'h000, 16'hA008, 4'h3);
      for (int m = 0; m < 2; m++)
      begin
         apb(1'b1, 12'h004, {11'h018, m[0], 4'h0}, 4'h3);
         lvl(1'b1, 5, "before clash");
         tv <= 3'h1;
         lvl(m == 0, 2, "clash");
         tv <= 3'h0;
      end
      for (int g = 0; g < 8; g++)
      begin
         apb(1'b1, 12'h00C, {1'b1, g[2:0], 12'h000}, 4'h3);
         repeat (4)
         begin
            @(posedge clk);
            chk(fa[1], peer[8 + g], "bypass");
         end
      end
      apb(1'b1, 12'h00C, 16'h0080, 4'h3);
      repeat (2) @(posedge clk);
      chk(fa[1], 32'h0000_0001, "no bypass");
      chk(la[1], 32'h0000_0001, "local one");
      apb(1'b1, 12'h018, 16'hFFFF, 4'h3);
      apb(1'b1, 12'h01C, 16'hFFFF, 4'h3);
      apb(1'b0, 12'h018, 16'h0000, 4'h3);
      chk(rd, 32'h0000_FF7F, "low");
      apb(1'b0, 12'h01C, 16'h0000, 4'h3);
      chk(rd, 32'h0000_F7FF, "high");
      apb(1'b1, 12'h018, 16'h0000, 4'h1);
      apb(1'b0, 12'h018, 16'h0000, 4'h3);
      chk(rd, 32'h0000_FF00, "strobe");
      apb(1'b0, 12'h020, 16'h0000, 4'h3);
      chk({rd[30:0], rerr}, 32'h0000_0001, "unmapped");
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, 12'h01C, 16'h0000, 4'h3);
      chk(rd, 32'h0000_0000, "reset");
      chk({la, fa}, 32'h0000_0000, "outputs after reset");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
